// ### hdl/iolp_pkg.sv
package iolp_pkg;
   // bus geometry
   localparam int DATA_W    = 32;
   localparam int ADDR_W    = 8;
   localparam int LINES_DEF = 32;

   // register byte addresses, one aligned word each
   localparam logic [7:0] OFF_MD_EN   = 8'h00;
   localparam logic [7:0] OFF_MD_DIS  = 8'h04;
   localparam logic [7:0] OFF_MD_STAT = 8'h08;
   localparam logic [7:0] OFF_PU_DIS  = 8'h10;
   localparam logic [7:0] OFF_PU_EN   = 8'h14;
   localparam logic [7:0] OFF_PU_STAT = 8'h18;
   localparam logic [7:0] OFF_FA_SEL  = 8'h20;
   localparam logic [7:0] OFF_FB_SEL  = 8'h24;
   localparam logic [7:0] OFF_FS_STAT = 8'h28;
   localparam logic [7:0] OFF_DW_EN   = 8'h30;
   localparam logic [7:0] OFF_DW_DIS  = 8'h34;
   localparam logic [7:0] OFF_DW_STAT = 8'h38;
   localparam logic [7:0] OFF_OD_STAT = 8'h3C;

   // index of each per-line setting bank
   localparam int CFG_MD = 0;
   localparam int CFG_PU = 1;
   localparam int CFG_SB = 2;
   localparam int CFG_OW = 3;
   localparam int CFG_N  = 4;

   // address that sets and clears each bank
   localparam logic [7:0] SET_OFF [CFG_N] =
      '{OFF_MD_EN, OFF_PU_DIS, OFF_FB_SEL, OFF_DW_EN};
   localparam logic [7:0] CLR_OFF [CFG_N] =
      '{OFF_MD_DIS, OFF_PU_EN, OFF_FA_SEL, OFF_DW_DIS};

   // reset values: push-pull, pull-up on, function a, writes blocked
   localparam logic [31:0] RST_CFG [CFG_N] =
      '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
   localparam logic [31:0] RST_ODSR = 32'h0000_0000;
   localparam logic [31:0] RD_ZERO  = 32'h0000_0000;
endpackage : iolp_pkg

// ### hdl/iolp_pad_if.sv
interface iolp_pad_if #(
   parameter int LINES = 32
);
   logic [LINES-1:0] md;     // open-drain per line
   logic [LINES-1:0] pu_off; // pull-up switched off
   logic [LINES-1:0] sel_b;  // function b owns the line outside controller mode
   logic [LINES-1:0] odata;  // output data status
   // register side drives the settings
   modport core (output md, output pu_off, output sel_b, output odata);
   // pad side only consumes them
   modport pad (input md, input pu_off, input sel_b, input odata);
endinterface : iolp_pad_if

// ### hdl/iolp_setclr_bank.sv
module iolp_setclr_bank #(
   parameter int          W   = 32,
   parameter logic [31:0] RST = 32'h0000_0000
) (
   input  wire logic         ref_clk_i,
   input  wire logic         rst_n_i,
   input  wire logic [W-1:0] set_i,   // ones set the line bit
   input  wire logic [W-1:0] clr_i,   // ones clear the line bit
   output logic      [W-1:0] state_o
);
   logic [W-1:0] state_ff;
   logic [W-1:0] nxt_state;

   // refuse widths the reset constant cannot cover
   if (W < 1 || W > 32)
   begin : g_chk
      $error("bank width out of range");
   end

   // set wins over a clear in the same cycle
   always_comb
   begin
      nxt_state = (state_ff & ~clr_i) | set_i;
   end

   // hold the per-line setting
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         state_ff <= RST[W-1:0];
      else
         state_ff <= nxt_state;
   end

   assign state_o = state_ff;
endmodule : iolp_setclr_bank

// ### hdl/iolp_pad_drv.sv
module iolp_pad_drv #(
   parameter int LINES = 32
) (
   input  wire logic             ref_clk_i,
   input  wire logic             rst_n_i,
   iolp_pad_if.pad               cfg,
   input  wire logic [LINES-1:0] pio_mode_i,
   input  wire logic [LINES-1:0] pio_drive_i,
   input  wire logic [LINES-1:0] fa_out_i,
   input  wire logic [LINES-1:0] fa_oe_i,
   input  wire logic [LINES-1:0] fb_out_i,
   input  wire logic [LINES-1:0] fb_oe_i,
   input  wire logic [LINES-1:0] pad_in_i,
   output logic      [LINES-1:0] pad_out_o,
   output logic      [LINES-1:0] pad_oe_n_o,
   output logic      [LINES-1:0] pad_pullup_o,
   output logic      [LINES-1:0] level_o
);
   logic [LINES-1:0] out_ff, oe_n_ff, pu_ff, sy1_ff, sy2_ff;
   logic [LINES-1:0] nxt_out, nxt_oe_n, nxt_pu;
   logic [LINES-1:0] src_d, src_e;

   // pick the source of each line, then shape the drive
   always_comb
   begin
      src_d = '0;
      src_e = '0;
      for (int i = 0; i < LINES; i++)
      begin
         if (pio_mode_i[i])
         begin
            src_d[i] = cfg.odata[i];
            src_e[i] = pio_drive_i[i];
         end
         else if (cfg.sel_b[i])
         begin
            src_d[i] = fb_out_i[i];
            src_e[i] = fb_oe_i[i];
         end
         else
         begin
            src_d[i] = fa_out_i[i];
            src_e[i] = fa_oe_i[i];
         end
      end
      nxt_out  = src_d & ~cfg.md;
      nxt_oe_n = ~(src_e & ~(cfg.md & src_d));
      nxt_pu   = ~cfg.pu_off;
   end

   // pad flops plus two-stage input synchroniser
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         out_ff  <= '0;
         oe_n_ff <= '1;
         pu_ff   <= '0;
         sy1_ff  <= '0;
         sy2_ff  <= '0;
      end
      else
      begin
         out_ff  <= nxt_out;
         oe_n_ff <= nxt_oe_n;
         pu_ff   <= nxt_pu;
         sy1_ff  <= pad_in_i;
         sy2_ff  <= sy1_ff;
      end
   end

   assign pad_out_o    = out_ff;
   assign pad_oe_n_o   = oe_n_ff;
   assign pad_pullup_o = pu_ff;
   assign level_o      = sy2_ff;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   chk_od_no_high: assert property (
      ($past(cfg.md) & ~oe_n_ff & out_ff) == '0)
      else $error("open-drain line driven high");
   chk_pp_follow: assert property (
      ($past(~cfg.md & pio_mode_i & pio_drive_i) & (oe_n_ff
       | (out_ff ^ $past(cfg.odata)))) == '0)
      else $error("push-pull line not driven with data");
endmodule : iolp_pad_drv

// ### hdl/iolp_line_cfg.sv
module iolp_line_cfg #(
   parameter int LINES = iolp_pkg::LINES_DEF
) (
   input  wire logic                       ref_clk_i,
   input  wire logic                       rst_n_i,
   input  wire logic [iolp_pkg::ADDR_W-1:0] reg_addr_i,
   input  wire logic [iolp_pkg::DATA_W-1:0] reg_wdata_i,
   input  wire logic                       reg_wr_i,
   input  wire logic                       reg_rd_i,
   output logic      [iolp_pkg::DATA_W-1:0] reg_rdata_o,
   input  wire logic [LINES-1:0]           line_pio_mode_i,
   input  wire logic [LINES-1:0]           line_drive_i,
   input  wire logic [LINES-1:0]           func_a_out_i,
   input  wire logic [LINES-1:0]           func_a_oe_i,
   input  wire logic [LINES-1:0]           func_b_out_i,
   input  wire logic [LINES-1:0]           func_b_oe_i,
   input  wire logic [LINES-1:0]           pad_in_i,
   output logic      [LINES-1:0]           pad_out_o,
   output logic      [LINES-1:0]           pad_oe_n_o,
   output logic      [LINES-1:0]           pad_pullup_o,
   output logic      [LINES-1:0]           line_level_o
);
   // line bits beyond the data word cannot be reached
   if (LINES < 1 || LINES > iolp_pkg::DATA_W)
   begin : g_chk
      $error("line count out of range");
   end

   // address match, used by the write decoders below
   function automatic logic hit(
      input logic [iolp_pkg::ADDR_W-1:0] a,
      input logic [iolp_pkg::ADDR_W-1:0] off
   );
      return a == off;
   endfunction : hit

   logic [LINES-1:0]            wdl;      // write data, line part
   logic [iolp_pkg::CFG_N-1:0]  set_hit;  // write to a set address
   logic [iolp_pkg::CFG_N-1:0]  clr_hit;  // write to a clear address
   logic [LINES-1:0]            cfg_q [iolp_pkg::CFG_N]; // bank states
   logic                        od_hit;   // write to output data
   logic [LINES-1:0]            md;       // open-drain per line
   logic [LINES-1:0]            pu_off;   // pull-up off per line
   logic [LINES-1:0]            sel_b;    // function b per line
   logic [LINES-1:0]            ow;       // direct write allowed
   logic [LINES-1:0]            odsr_ff;  // output data status
   logic [LINES-1:0]            nxt_odsr;
   logic [iolp_pkg::DATA_W-1:0] rdata_ff; // read answer
   logic [iolp_pkg::DATA_W-1:0] nxt_rdata;

   // line part of the write word
   assign wdl = reg_wdata_i[LINES-1:0];

   // write decode and one set/clear bank per setting
   // one bit per line in each setting
   for (genvar k = 0; k < iolp_pkg::CFG_N; k++)
   begin : g_bank
      assign set_hit[k] = reg_wr_i
                          && hit(reg_addr_i, iolp_pkg::SET_OFF[k]);
      assign clr_hit[k] = reg_wr_i
                          && hit(reg_addr_i, iolp_pkg::CLR_OFF[k]);
      iolp_setclr_bank #(
         .W   (LINES),
         .RST (iolp_pkg::RST_CFG[k])
      ) u_bank (
         .ref_clk_i (ref_clk_i),
         .rst_n_i   (rst_n_i),
         .set_i     (set_hit[k] ? wdl : '0),
         .clr_i     (clr_hit[k] ? wdl : '0),
         .state_o   (cfg_q[k])
      );
   end

   // named views of the banks
   // open-drain on
   assign md     = cfg_q[iolp_pkg::CFG_MD];
   assign pu_off = cfg_q[iolp_pkg::CFG_PU];
   assign sel_b  = cfg_q[iolp_pkg::CFG_SB];
   assign ow     = cfg_q[iolp_pkg::CFG_OW];

   // direct write of output data
   assign od_hit = reg_wr_i && hit(reg_addr_i, iolp_pkg::OFF_OD_STAT);

   // output data next value, masked per line
   always_comb
   begin
      nxt_odsr = odsr_ff;
      if (od_hit)
      begin
         nxt_odsr = (odsr_ff & ~ow) | (wdl & ow);
      end
   end

   // output data register
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         odsr_ff <= iolp_pkg::RST_ODSR[LINES-1:0];
      else
         odsr_ff <= nxt_odsr;
   end

   // read mux; answer stands only in the cycle after
   always_comb
   begin
      nxt_rdata = iolp_pkg::RD_ZERO;
      if (reg_rd_i)
      begin
         unique case (reg_addr_i)
            iolp_pkg::OFF_MD_STAT:
               nxt_rdata = iolp_pkg::DATA_W'(md);
            iolp_pkg::OFF_PU_STAT:
               nxt_rdata = iolp_pkg::DATA_W'(pu_off);
            iolp_pkg::OFF_FS_STAT:
               nxt_rdata = iolp_pkg::DATA_W'(sel_b);
            iolp_pkg::OFF_DW_STAT:
               nxt_rdata = iolp_pkg::DATA_W'(ow);
            iolp_pkg::OFF_OD_STAT:
               nxt_rdata = iolp_pkg::DATA_W'(odsr_ff);
            // write-only and unmapped read as zero
            default:
               nxt_rdata = iolp_pkg::RD_ZERO;
         endcase
      end
   end

   // read data register
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         rdata_ff <= iolp_pkg::RD_ZERO;
      else
         rdata_ff <= nxt_rdata;
   end

   assign reg_rdata_o = rdata_ff;

   // settings travel to the pad side together
   iolp_pad_if #(.LINES(LINES)) u_if ();

   // register side of the interface
   assign u_if.md     = md;
   assign u_if.pu_off = pu_off;
   assign u_if.sel_b  = sel_b;
   assign u_if.odata  = odsr_ff;

   // pad shaping, registered outputs
   // push-pull when status zero
   iolp_pad_drv #(
      .LINES (LINES)
   ) u_pad (
      .ref_clk_i    (ref_clk_i),
      .rst_n_i      (rst_n_i),
      .cfg          (u_if.pad),
      .pio_mode_i   (line_pio_mode_i),
      .pio_drive_i  (line_drive_i),
      .fa_out_i     (func_a_out_i),
      .fa_oe_i      (func_a_oe_i),
      .fb_out_i     (func_b_out_i),
      .fb_oe_i      (func_b_oe_i),
      .pad_in_i     (pad_in_i),
      .pad_out_o    (pad_out_o),
      .pad_oe_n_o   (pad_oe_n_o),
      .pad_pullup_o (pad_pullup_o),
      .level_o      (line_level_o)
   );

   // checks on the register side
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   // helper: status word as the bus would show it
   function automatic logic [iolp_pkg::DATA_W-1:0] ext(
      input logic [LINES-1:0] v
   );
      return iolp_pkg::DATA_W'(v);
   endfunction : ext

   chk_md_enable: assert property (
      set_hit[iolp_pkg::CFG_MD]
      |=> md == ($past(md) | $past(wdl)))
      else $error("open-drain enable write wrong");

   chk_md_disable: assert property (
      clr_hit[iolp_pkg::CFG_MD]
      |=> md == ($past(md) & ~$past(wdl)))
      else $error("open-drain disable write wrong");

   chk_pu_disable: assert property (
      set_hit[iolp_pkg::CFG_PU]
      |=> pu_off == ($past(pu_off) | $past(wdl)))
      else $error("pull-up disable write wrong");

   chk_pu_enable: assert property (
      clr_hit[iolp_pkg::CFG_PU]
      ##1 !set_hit[iolp_pkg::CFG_PU]
      |=> pad_pullup_o == ~($past(pu_off, 2) & ~$past(wdl, 2)))
      else $error("pull-up enable did not reach pad");

   chk_pu_status: assert property (
      reg_rd_i && hit(reg_addr_i, iolp_pkg::OFF_PU_STAT)
      |=> reg_rdata_o == ext($past(pu_off)))
      else $error("pull-up status read wrong");

   chk_sel_a: assert property (
      clr_hit[iolp_pkg::CFG_SB]
      |=> sel_b == ($past(sel_b) & ~$past(wdl)))
      else $error("function a select wrong");

   chk_sel_b: assert property (
      set_hit[iolp_pkg::CFG_SB]
      |=> sel_b == ($past(sel_b) | $past(wdl)))
      else $error("function b select wrong");

   chk_sel_status: assert property (
      reg_rd_i && hit(reg_addr_i, iolp_pkg::OFF_FS_STAT)
      |=> reg_rdata_o == ext($past(sel_b)))
      else $error("function status read wrong");

   chk_ow_enable: assert property (
      set_hit[iolp_pkg::CFG_OW] ##1 od_hit
      |=> ((odsr_ff ^ $past(wdl)) & $past(wdl, 2)) == '0)
      else $error("enabled line not written");

   chk_ow_block: assert property (
      od_hit |=> ((odsr_ff ^ $past(odsr_ff)) & ~$past(ow)) == '0)
      else $error("blocked line changed");

   chk_ow_status: assert property (
      reg_rd_i && hit(reg_addr_i, iolp_pkg::OFF_DW_STAT)
      |=> reg_rdata_o == ext($past(ow)))
      else $error("write status read wrong");

   chk_md_hold: assert property (
      !set_hit[iolp_pkg::CFG_MD] && !clr_hit[iolp_pkg::CFG_MD]
      |=> $stable(md))
      else $error("open-drain bit changed unasked");

   chk_md_status: assert property (
      reg_rd_i && hit(reg_addr_i, iolp_pkg::OFF_MD_STAT)
      |=> reg_rdata_o == ext($past(md)))
      else $error("open-drain status read wrong");

   chk_rd_once: assert property (
      !reg_rd_i |=> reg_rdata_o == iolp_pkg::RD_ZERO)
      else $error("read data outside answer cycle");

   // pull-up bank, enable side
   chk_pu_clear: assert property (
      clr_hit[iolp_pkg::CFG_PU]
      |=> pu_off == ($past(pu_off) & ~$past(wdl)))
      else $error("pull-up enable write wrong");

   // pull-up off at the pad two edges after the write
   chk_pu_off_pad: assert property (
      set_hit[iolp_pkg::CFG_PU]
      |-> ##2 (pad_pullup_o & $past(wdl, 2)) == '0)
      else $error("pull-up disable did not reach pad");

   // direct write gate, both directions
   chk_ow_set: assert property (
      set_hit[iolp_pkg::CFG_OW]
      |=> ow == ($past(ow) | $past(wdl)))
      else $error("direct write enable wrong");

   chk_ow_clear: assert property (
      clr_hit[iolp_pkg::CFG_OW]
      |=> ow == ($past(ow) & ~$past(wdl)))
      else $error("direct write disable wrong");

   // banks keep their bits between writes
   chk_pu_hold: assert property (
      !set_hit[iolp_pkg::CFG_PU] && !clr_hit[iolp_pkg::CFG_PU]
      |=> $stable(pu_off))
      else $error("pull-up bit changed unasked");

   chk_sel_hold: assert property (
      !set_hit[iolp_pkg::CFG_SB] && !clr_hit[iolp_pkg::CFG_SB]
      |=> $stable(sel_b))
      else $error("function bit changed unasked");

   chk_ow_hold: assert property (
      !set_hit[iolp_pkg::CFG_OW] && !clr_hit[iolp_pkg::CFG_OW]
      |=> $stable(ow))
      else $error("write gate bit changed unasked");

   // output data only moves on its own write
   chk_od_hold: assert property (
      !od_hit |=> $stable(odsr_ff))
      else $error("output data changed without write");

   chk_od_read: assert property (
      reg_rd_i && hit(reg_addr_i, iolp_pkg::OFF_OD_STAT)
      |=> reg_rdata_o == ext($past(odsr_ff)))
      else $error("output data read wrong");

   // the write-only open-drain enable address answers zero
   chk_wo_read: assert property (
      reg_rd_i && hit(reg_addr_i, iolp_pkg::OFF_MD_EN)
      |=> reg_rdata_o == iolp_pkg::RD_ZERO)
      else $error("write-only read not zero");

   // open-drain lines at the pins, controller mode
   chk_od_low: assert property (
      ($past(md & line_pio_mode_i & line_drive_i & ~odsr_ff)
       & (pad_oe_n_o | pad_out_o)) == '0)
      else $error("open-drain line not driven low");

   chk_od_release: assert property (
      ($past(md & line_pio_mode_i & odsr_ff) & ~pad_oe_n_o) == '0)
      else $error("open-drain line not released");

   // main scenarios
   cov_md_on: cover property (
      set_hit[iolp_pkg::CFG_MD] ##1 md != '0);
   cov_sel_b: cover property (
      set_hit[iolp_pkg::CFG_SB] ##1 reg_rd_i);
   cov_od_write: cover property (
      set_hit[iolp_pkg::CFG_OW] ##[1:4] od_hit);
   cov_pu_off: cover property (
      set_hit[iolp_pkg::CFG_PU] ##2 pad_pullup_o != '1);
   cov_od_blocked: cover property (
      od_hit && ow != '1);
endmodule : iolp_line_cfg

// ### verification/iolp_pad_model.sv
// pins outside the block: resolves each line from the pad drivers
module iolp_pad_model (
   input  wire logic        ref_clk_i,
   input  wire logic [31:0] pad_out_i,
   input  wire logic [31:0] pad_oe_n_i,
   input  wire logic [31:0] pad_pullup_i,
   output logic      [31:0] pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic flip_ff = 1'b0; // floating lines wander every cycle
   // toggle source for undriven, unpulled lines
   always_ff @(posedge ref_clk_i)
   begin
      flip_ff <= ~flip_ff;
   end
   // driven value wins, then pull-up, else a changing level
   always_comb
   begin
      for (int i = 0; i < 32; i++)
         pin_o[i] = !pad_oe_n_i[i] ? pad_out_i[i] :
                    pad_pullup_i[i] ? 1'b1 : flip_ff ^ i[0];
   end
endmodule : iolp_pad_model

// ### verification/iolp_line_cfg_tb.sv
// self-checking bench for the line configuration block
module iolp_line_cfg_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LIMIT = 20000; // cycle ceiling for a hung run
   logic        ref_clk_i = 1'b0;
   logic        rst_n_i   = 1'b0;
   logic [7:0]  reg_addr_i  = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0000_0000;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic [31:0] reg_rdata_o, pad_out_o, pad_oe_n_o, pad_pullup_o;
   logic [31:0] line_level_o, pad_in_i;
   logic [31:0] mode_i = '0, drive_i = '0, fa_o = '0, fa_e = '0;
   logic [31:0] fb_o = '0, fb_e = '0;
   logic [31:0] cfg_q [4];   // expected bank contents
   logic [31:0] od_q;        // expected output data
   logic [7:0]  stat_off [4] = '{iolp_pkg::OFF_MD_STAT,
      iolp_pkg::OFF_PU_STAT, iolp_pkg::OFF_FS_STAT, iolp_pkg::OFF_DW_STAT};
   int          num_errors = 0;
   int          comparisons = 0;
   int          cycles = 0;

   iolp_line_cfg DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .line_pio_mode_i(mode_i), .line_drive_i(drive_i),
      .func_a_out_i(fa_o), .func_a_oe_i(fa_e), .func_b_out_i(fb_o),
      .func_b_oe_i(fb_e), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o),
      .pad_oe_n_o(pad_oe_n_o), .pad_pullup_o(pad_pullup_o),
      .line_level_o(line_level_o));
   iolp_pad_model pads (.ref_clk_i(ref_clk_i), .pad_out_i(pad_out_o),
      .pad_oe_n_i(pad_oe_n_o), .pad_pullup_i(pad_pullup_o),
      .pin_o(pad_in_i));

   // free-running clock, 5 ns period
   always #2.5 ref_clk_i = ~ref_clk_i;

   // hang guard
   always @(posedge ref_clk_i)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         num_errors++;
         finish_test();
      end
   end

   // compare and report
   task automatic chk(input string what, input logic [31:0] e,
                      input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask : chk

   // one-cycle write strobe
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
   endtask : reg_wr

   // one-cycle read strobe, data taken in the following cycle
   task automatic reg_chk(input string what, input logic [7:0] a,
                          input logic [31:0] e);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      #1 chk(what, e, reg_rdata_o);
   endtask : reg_chk

   // set or clear write to a bank, mirrored in the expectation
   task automatic bank_wr(input int k, input bit set, input logic [31:0] d);
      reg_wr(set ? iolp_pkg::SET_OFF[k] : iolp_pkg::CLR_OFF[k], d);
      cfg_q[k] = set ? (cfg_q[k] | d) : (cfg_q[k] & ~d);
   endtask : bank_wr

   // pad outputs worked out from settings and sources
   task automatic pads_chk;
      logic [31:0] d, en, drv, lvl, msk;
      repeat (2) @(posedge ref_clk_i);
      #1;
      d   = (mode_i & od_q) | (~mode_i & cfg_q[2] & fb_o)
          | (~mode_i & ~cfg_q[2] & fa_o);
      en  = (mode_i & drive_i) | (~mode_i & cfg_q[2] & fb_e)
          | (~mode_i & ~cfg_q[2] & fa_e);
      drv = en & ~(cfg_q[0] & d);
      chk("pad_oe_n", ~drv, pad_oe_n_o);
      chk("pad_out", d & drv, pad_out_o & drv);
      chk("pad_pullup", ~cfg_q[1], pad_pullup_o);
      // pin level seen back: driven data, else pull-up; floating skipped
      lvl = (drv & d) | (~drv & ~cfg_q[1]);
      msk = drv | ~cfg_q[1];
      chk("line_level", lvl, line_level_o & msk);
   endtask : pads_chk

   // closing report
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test

   // main sequence
   initial
   begin
      void'($urandom(32'hDD6812AA));
      foreach (cfg_q[k])
         cfg_q[k] = 32'h0000_0000;
      od_q = 32'h0000_0000;
      repeat (3) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      // reset values and refused accesses
      for (int k = 0; k < 4; k++)
         reg_chk("status", stat_off[k], 32'h0000_0000);
      pads_chk();
      reg_chk("write only", iolp_pkg::OFF_MD_EN, 32'h0000_0000);
      reg_chk("unmapped", 8'hFC, 32'h0000_0000);
      reg_wr(iolp_pkg::OFF_MD_STAT, 32'hFFFF_FFFF);
      reg_chk("status write", iolp_pkg::OFF_MD_STAT, '0);
      $display("test reset done");
      // all lines on, then zero-data writes leave them alone
      for (int k = 0; k < 4; k++)
      begin
         bank_wr(k, 1'b1, 32'hFFFF_FFFF);
         bank_wr(k, 1'b0, 32'h0000_0000);
         reg_chk("bank full", stat_off[k], cfg_q[k]);
         bank_wr(k, 1'b0, 32'hFFFF_FFFF);
         bank_wr(k, 1'b1, 32'h0000_0000);
         reg_chk("bank empty", stat_off[k], cfg_q[k]);
      end
      $display("test boundaries done");
      // random mix of settings, output data and pad sources
      repeat (300)
      begin
         @(posedge ref_clk_i);
         mode_i  <= $urandom;
         drive_i <= $urandom;
         fa_o    <= $urandom;
         fa_e    <= $urandom;
         fb_o    <= $urandom;
         fb_e    <= $urandom;
         reg_wdata_i <= $urandom;
         if ($urandom_range(0, 4) < 4)
            bank_wr($urandom_range(0, 3), 1'($urandom), $urandom);
         else
         begin
            reg_wr(iolp_pkg::OFF_OD_STAT, $urandom);
            od_q = (od_q & ~cfg_q[3]) | (reg_wdata_i & cfg_q[3]);
         end
         reg_chk("multi drive", stat_off[0], cfg_q[0]);
         reg_chk("pullup", stat_off[1], cfg_q[1]);
         reg_chk("function", stat_off[2], cfg_q[2]);
         reg_chk("write gate", stat_off[3], cfg_q[3]);
         reg_chk("out data", iolp_pkg::OFF_OD_STAT, od_q);
         pads_chk();
      end
      $display("test random done");
      finish_test();
   end
endmodule : iolp_line_cfg_tb
